// *** inc/pscd_defines.vh ***
/*
 Constants for the strap configuration decoder: four-level strap codes,
 mode encodings, boost and swing/de-emphasis tables and register defaults.
 Assumes the analog front end already quantises each strap pin into a
 two-bit level code before it reaches the logic.
*/
`ifndef PSCD_DEFINES_VH
`define PSCD_DEFINES_VH

// Four-level strap codes, ordered by pin voltage
`define PSCD_LVL_0 2'h0
`define PSCD_LVL_R 2'h1
`define PSCD_LVL_F 2'h2
`define PSCD_LVL_1 2'h3

// Operating modes
`define PSCD_MODE_PIN 2'h0
`define PSCD_MODE_SLAVE 2'h1
`define PSCD_MODE_MASTER 2'h2

// Boost codes, index = {hi, lo}
`define PSCD_EQ_0 8'h00
`define PSCD_EQ_1 8'h01
`define PSCD_EQ_2 8'h02
`define PSCD_EQ_3 8'h03
`define PSCD_EQ_4 8'h07
`define PSCD_EQ_5 8'h15
`define PSCD_EQ_6 8'h0b
`define PSCD_EQ_7 8'h0f
`define PSCD_EQ_8 8'h55
`define PSCD_EQ_9 8'h1f
`define PSCD_EQ_10 8'h2f
`define PSCD_EQ_11 8'h3f
`define PSCD_EQ_12 8'haa
`define PSCD_EQ_13 8'h7f
`define PSCD_EQ_14 8'hbf
`define PSCD_EQ_15 8'hff

// Swing codes, value = tenths of a volt peak-to-peak
`define PSCD_SW_06 4'h6
`define PSCD_SW_08 4'h8
`define PSCD_SW_09 4'h9
`define PSCD_SW_10 4'ha
`define PSCD_SW_11 4'hb
`define PSCD_SW_12 4'hc

// De-emphasis codes
`define PSCD_DE_0DB 2'h0
`define PSCD_DE_3P5DB 2'h1
`define PSCD_DE_6DB 2'h2
`define PSCD_DE_9DB 2'h3

// Register defaults
`define PSCD_DEF_EQ 8'h00
`define PSCD_DEF_SW 4'ha
`define PSCD_DEF_DE 2'h0
`define PSCD_DEF_TERM 1'h0

`endif

// *** sim/pscd_board_model.sv ***
/* Board side: strap resistors as level codes, mode and hold pins, bus host writes.
   Assumes the bench calls its tasks; all pins move 1 ns after a rising edge. */
module pscd_board_model (
  input wire clock_i,
  output logic [15:0] straps_o,
  output logic [1:0] mode_pin_o,
  output logic hold_o,
  output logic wr_o,
  output logic [1:0] lane_o,
  output logic [14:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {straps_o, mode_pin_o, hold_o, wr_o, lane_o, data_o} = '0;
  end
  // Levels 0, R, Float, 1 as codes 0 to 3
  task automatic set_pins(input logic [15:0] s, input logic [1:0] m, input logic h);
    @(posedge clock_i);
    #1 {straps_o, mode_pin_o, hold_o} = {s, m, h};
  endtask
  // One strobe per lane; data inverted once released so stale values never match
  task automatic write_lane(input logic [1:0] l, input logic [14:0] d);
    @(posedge clock_i);
    #1 {wr_o, lane_o, data_o} = {1'b1, l, d};
    @(posedge clock_i);
    #1 {wr_o, lane_o, data_o} = {1'b0, ~l, ~d};
  endtask
endmodule // pscd_board_model

// *** sim/pscd_strap_decoder_asserts.sv ***
/* Checker for the strap decoder: mode, address straps, strap tables, writes, hold.
   Assumes a three-edge pin latency and a two-edge write latency at the ports. */
module pscd_strap_decoder_asserts #(
  parameter LANES = 4
) (
  input wire clock_i,
  input wire reset_n_i,
  input wire [1:0] mgmt_bus_mode_pin_i,
  input wire hold_pin_i,
  input wire [1:0] dside_boost_hi_strap_i,
  input wire [1:0] dside_boost_lo_strap_i,
  input wire [1:0] sside_boost_hi_strap_i,
  input wire [1:0] sside_boost_lo_strap_i,
  input wire [1:0] dside_deemph_hi_strap_i,
  input wire [1:0] dside_deemph_lo_strap_i,
  input wire [1:0] sside_deemph_hi_strap_i,
  input wire [1:0] sside_deemph_lo_strap_i,
  input wire reg_wr_i,
  input wire [1:0] reg_lane_i,
  input wire [7:0] reg_boost_i,
  input wire [3:0] reg_swing_i,
  input wire [1:0] reg_deemph_i,
  input wire reg_term_dis_i,
  input wire [1:0] mode_o,
  input wire [3:0] bus_addr_straps_o,
  input wire [8*LANES-1:0] ctle_boost_o,
  input wire [4*LANES-1:0] output_swing_o,
  input wire [2*LANES-1:0] deemph_o,
  input wire [LANES-1:0] term_dis_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [127:0] EQT = 128'hffbf7faa3f2f1f550f0b150703020100;
  // Sixteen {swing, deemph} pairs, entry 0 in the low six bits
  localparam logic [95:0] SDT = 96'hcf2c70badb2aa689a5921818;
  logic [2:0] up_q;
  wire [1:0] mm = (mgmt_bus_mode_pin_i == 2'h3) ? 2'h1 : (mgmt_bus_mode_pin_i == 2'h2) ? 2'h2 : 2'h0;
  wire [3:0] deq = {dside_boost_hi_strap_i, dside_boost_lo_strap_i};
  wire [3:0] seq = {sside_boost_hi_strap_i, sside_boost_lo_strap_i};
  wire [3:0] dde = {dside_deemph_hi_strap_i, dside_deemph_lo_strap_i};
  wire [3:0] sde = {sside_deemph_hi_strap_i, sside_deemph_lo_strap_i};
  wire [3:0] ad = {sside_deemph_hi_strap_i[1], dside_deemph_hi_strap_i[1],
                   sside_boost_hi_strap_i[1], dside_boost_hi_strap_i[1]};
  wire [14:0] wdat = {reg_boost_i, reg_swing_i, reg_deemph_i, reg_term_dis_i};
  wire [14:0] lf [4];
  wire warm = (up_q == 3'h4);
  // Per-lane view of all four fields, same order as a write
  for (genvar i = 0; i < 4; i++)
  begin : g_lf
    assign lf[i] = {ctle_boost_o[8*i+:8], output_swing_o[4*i+:4], deemph_o[2*i+:2], term_dis_o[i]};
  end
  // Edges since reset; the pin pipeline is not full before the fourth
  always @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i) up_q <= 3'h0;
    else if (up_q != 3'h4) up_q <= up_q + 3'h1;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  AST_MODE: assert property (warm |-> mode_o == $past(mm, 3)) else $error("mode decode wrong");
  AST_ADDR_BUS: assert property (warm && mode_o != 2'h0 |-> bus_addr_straps_o == $past(ad, 3))
    else $error("address straps wrong");
  AST_ADDR_PIN: assert property (warm && mode_o == 2'h0 |-> bus_addr_straps_o == 4'h0)
    else $error("address not cleared in pin mode");
  AST_D_BOOST: assert property (warm && mode_o == 2'h0 |-> ctle_boost_o[15:0] == {2{EQT[8*$past(deq, 3)+:8]}})
    else $error("D boost wrong");
  AST_S_BOOST: assert property (warm && mode_o == 2'h0 |-> ctle_boost_o[31:16] == {2{EQT[8*$past(seq, 3)+:8]}})
    else $error("S boost wrong");
  AST_D_SWING: assert property (warm && mode_o == 2'h0 |-> {output_swing_o[3:0], deemph_o[1:0]} == SDT[6*$past(dde, 3)+:6])
    else $error("D swing wrong");
  AST_S_SWING: assert property (warm && mode_o == 2'h0 |-> {output_swing_o[15:12], deemph_o[7:6]} == SDT[6*$past(sde, 3)+:6])
    else $error("S swing wrong");
  AST_WRITE: assert property (warm && reg_wr_i && $past(mm, 2) == 2'h2 && $past(mm) == 2'h2 |-> ##2 lf[$past(reg_lane_i, 2)] == $past(wdat, 2))
    else $error("lane write lost");
  AST_HOLD: assert property ((mode_o == 2'h1 && hold_pin_i)[*5] |-> $stable(ctle_boost_o) && $stable(output_swing_o))
    else $error("bank changed while held");
  cover property (mode_o == 2'h2 && reg_wr_i);
  cover property (mode_o == 2'h1 && hold_pin_i && reg_wr_i);
  cover property (mode_o == 2'h0 && ctle_boost_o[7:0] == 8'hff);
endmodule // pscd_strap_decoder_asserts

bind pscd_strap_decoder pscd_strap_decoder_asserts #(.LANES(LANES)) u_chk (.*);

// *** sim/test_pin_strap_config_decoder.sv ***
/* Bench for the strap decoder: pin tables, bus-mode writes, hold, mode resets.
   Assumes the board model drives every input but clock and reset; expectations come from local tables. */
module test_pin_strap_config_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  wire [15:0] st;
  wire [1:0] mp, ln;
  wire [14:0] wd;
  wire hold, wr;
  wire [65:0] seen;
  logic [65:0] q [$];
  logic [14:0] bank [4] = '{default: 15'h0050};
  logic [15:0] s;
  logic [14:0] d;
  int num_errors = 0;
  int compares = 0;
  event smp;
  localparam logic [127:0] EQT = 128'hffbf7faa3f2f1f550f0b150703020100;
  localparam logic [95:0] SDT = 96'hcf2c70badb2aa689a5921818;
  localparam logic [65:0] DEF = {38'h0, 16'haaaa, 12'h0};
  pscd_board_model brd (.clock_i(clock_i), .straps_o(st), .mode_pin_o(mp), .hold_o(hold),
    .wr_o(wr), .lane_o(ln), .data_o(wd));
  pscd_strap_decoder #(.LANES(4)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .mgmt_bus_mode_pin_i(mp), .hold_pin_i(hold),
    .dside_boost_hi_strap_i(st[15:14]), .dside_boost_lo_strap_i(st[13:12]),
    .sside_boost_hi_strap_i(st[11:10]), .sside_boost_lo_strap_i(st[9:8]),
    .dside_deemph_hi_strap_i(st[7:6]), .dside_deemph_lo_strap_i(st[5:4]),
    .sside_deemph_hi_strap_i(st[3:2]), .sside_deemph_lo_strap_i(st[1:0]),
    .reg_wr_i(wr), .reg_lane_i(ln), .reg_boost_i(wd[14:7]), .reg_swing_i(wd[6:3]),
    .reg_deemph_i(wd[2:1]), .reg_term_dis_i(wd[0]), .mode_o(seen[65:64]),
    .bus_addr_straps_o(seen[63:60]), .ctle_boost_o(seen[59:28]),
    .output_swing_o(seen[27:12]), .deemph_o(seen[11:4]), .term_dis_o(seen[3:0]));
  initial
  begin
    forever #4 clock_i = ~clock_i;
  end
  function automatic logic [65:0] pin_exp(input logic [15:0] x);
    logic [7:0] ed, es;
    logic [5:0] xd, xs;
    ed = EQT[8*x[15:12]+:8];
    es = EQT[8*x[11:8]+:8];
    xd = SDT[6*x[7:4]+:6];
    xs = SDT[6*x[3:0]+:6];
    return {6'h0, es, es, ed, ed, {2{xs[5:2]}}, {2{xd[5:2]}}, {2{xs[1:0]}}, {2{xd[1:0]}}, 4'h0};
  endfunction
  function automatic logic [65:0] bus_exp(input logic [1:0] m, input logic [15:0] x);
    logic [31:0] b;
    logic [15:0] w;
    logic [7:0] e;
    logic [3:0] t;
    for (int i = 0; i < 4; i++) {b[8*i+:8], w[4*i+:4], e[2*i+:2], t[i]} = bank[i];
    return {m, x[3], x[7], x[11], x[15], b, w, e, t};
  endfunction
  task automatic check(input logic [65:0] got, input logic [65:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Note the result, let the pin pipeline settle, then wake the monitor
  task automatic expect_now(input logic [65:0] e);
    q.push_back(e);
    repeat (4) @(posedge clock_i);
    #2 -> smp;
  endtask
  task automatic wr_lane(input logic [1:0] l, input logic keep);
    d = 15'($urandom);
    if (keep) bank[l] = d;
    brd.write_lane(l, d);
  endtask
  task automatic end_of_test;
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(smp) check(seen, q.pop_front());
  initial
  begin
    #50us;
    num_errors++;
    end_of_test;
  end
  initial
  begin
    void'($urandom(62));
    repeat (11) @(posedge clock_i);
    expect_now(DEF);
    // Release on the sixteenth edge, same skew as every other input
    @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    // Every boost entry on both sides, every swing entry on D side only; mode code R also counts as pin mode
    for (int i = 0; i < 16; i++)
    begin
      s = {i[3:0], 4'(15 - i), i[3:0], 4'($urandom)};
      brd.set_pins(s, {1'b0, i[0]}, 1'b0);
      wr_lane(i[1:0], 1'b0);
      expect_now(pin_exp(s));
    end
    s = 16'($urandom);
    brd.set_pins(s, 2'h2, 1'b0);
    expect_now(bus_exp(2'h2, s));
    for (int l = 0; l < 4; l++) wr_lane(l[1:0], 1'b1);
    expect_now(bus_exp(2'h2, s));
    brd.set_pins(s, 2'h3, 1'b1);
    expect_now(bus_exp(2'h1, s));
    wr_lane(2'h2, 1'b0);
    expect_now(bus_exp(2'h1, s));
    brd.set_pins(s, 2'h3, 1'b0);
    expect_now(bus_exp(2'h1, s));
    wr_lane(2'h1, 1'b1);
    expect_now(bus_exp(2'h1, s));
    brd.set_pins(s, 2'h0, 1'b0);
    bank = '{default: 15'h0050};
    expect_now(pin_exp(s));
    brd.set_pins(s, 2'h3, 1'b0);
    expect_now(bus_exp(2'h1, s));
    end_of_test;
  end
endmodule // test_pin_strap_config_decoder

// *** src/pscd_strap_decoder.v ***
/*
 Configuration source selection for a four-lane mux/buffer. Strap decode
 in pin mode, per-lane register bank in bus modes, address straps.
 Assumes strap pins arrive as two-bit level codes from comparators and the
 mode pin as a two-bit code; all pins are asynchronous and get synchronised.
 The bus protocol engine writes the bank through a simple write strobe.
*/
`include "pscd_defines.vh"

module pscd_strap_decoder #(
  parameter LANES = 4
) (
  input wire clock_i,
  input wire reset_n_i,
  input wire [1:0] mgmt_bus_mode_pin_i,
  input wire hold_pin_i,
  input wire [1:0] dside_boost_hi_strap_i,
  input wire [1:0] dside_boost_lo_strap_i,
  input wire [1:0] sside_boost_hi_strap_i,
  input wire [1:0] sside_boost_lo_strap_i,
  input wire [1:0] dside_deemph_hi_strap_i,
  input wire [1:0] dside_deemph_lo_strap_i,
  input wire [1:0] sside_deemph_hi_strap_i,
  input wire [1:0] sside_deemph_lo_strap_i,
  input wire reg_wr_i,
  input wire [1:0] reg_lane_i,
  input wire [7:0] reg_boost_i,
  input wire [3:0] reg_swing_i,
  input wire [1:0] reg_deemph_i,
  input wire reg_term_dis_i,
  output reg [1:0] mode_o,
  output reg [3:0] bus_addr_straps_o,
  output reg [8*LANES-1:0] ctle_boost_o,
  output reg [4*LANES-1:0] output_swing_o,
  output reg [2*LANES-1:0] deemph_o,
  output reg [LANES-1:0] term_dis_o
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers: two flops per pin, stage one read by stage two only
  localparam SW = 20; // Mode, one spare bit, hold, eight straps of two bits
  wire [SW-1:0] raw_w;
  reg [SW-1:0] s1_q;
  reg [SW-1:0] s2_q;
  assign raw_w = {mgmt_bus_mode_pin_i, 1'b0, hold_pin_i,
                  dside_boost_hi_strap_i, dside_boost_lo_strap_i,
                  sside_boost_hi_strap_i, sside_boost_lo_strap_i,
                  dside_deemph_hi_strap_i, dside_deemph_lo_strap_i,
                  sside_deemph_hi_strap_i, sside_deemph_lo_strap_i};

  // Double-flop every asynchronous pin
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s1_q <= {SW{1'b0}};
      s2_q <= {SW{1'b0}};
    end
    else
    begin
      s1_q <= raw_w;
      s2_q <= s1_q;
    end
  end

  wire [1:0] mode_pin_w = s2_q[19:18];
  wire hold_w = s2_q[16];
  wire [1:0] d_eq_hi_w = s2_q[15:14];
  wire [1:0] d_eq_lo_w = s2_q[13:12];
  wire [1:0] s_eq_hi_w = s2_q[11:10];
  wire [1:0] s_eq_lo_w = s2_q[9:8];
  wire [1:0] d_de_hi_w = s2_q[7:6];
  wire [1:0] d_de_lo_w = s2_q[5:4];
  wire [1:0] s_de_hi_w = s2_q[3:2];
  wire [1:0] s_de_lo_w = s2_q[1:0];

  ////////////////////////////////////////////////////////////////////////
  // Mode decode: low pin, high slave, float master
  reg [1:0] mode_w;
  always @*
  begin
    case (mode_pin_w)
      `PSCD_LVL_0: mode_w = `PSCD_MODE_PIN;
      `PSCD_LVL_1: mode_w = `PSCD_MODE_SLAVE;
      `PSCD_LVL_F: mode_w = `PSCD_MODE_MASTER;
      default: mode_w = `PSCD_MODE_PIN; // R level unused, treat as pin
    endcase
  end
  wire pin_mode_w = (mode_w == `PSCD_MODE_PIN);

  ////////////////////////////////////////////////////////////////////////
  // Boost lookup from the two four-level straps
  function [7:0] boost_lut;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: boost_lut = `PSCD_EQ_0;
        4'h1: boost_lut = `PSCD_EQ_1;
        4'h2: boost_lut = `PSCD_EQ_2;
        4'h3: boost_lut = `PSCD_EQ_3;
        4'h4: boost_lut = `PSCD_EQ_4;
        4'h5: boost_lut = `PSCD_EQ_5;
        4'h6: boost_lut = `PSCD_EQ_6;
        4'h7: boost_lut = `PSCD_EQ_7;
        4'h8: boost_lut = `PSCD_EQ_8;
        4'h9: boost_lut = `PSCD_EQ_9;
        4'ha: boost_lut = `PSCD_EQ_10;
        4'hb: boost_lut = `PSCD_EQ_11;
        4'hc: boost_lut = `PSCD_EQ_12;
        4'hd: boost_lut = `PSCD_EQ_13;
        4'he: boost_lut = `PSCD_EQ_14;
        default: boost_lut = `PSCD_EQ_15;
      endcase
    end
  endfunction

  // Swing and de-emphasis pair lookup, {swing, deemph}
  function [5:0] demph_lut;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: demph_lut = {`PSCD_SW_06, `PSCD_DE_0DB};
        4'h1: demph_lut = {`PSCD_SW_08, `PSCD_DE_0DB};
        4'h2: demph_lut = {`PSCD_SW_08, `PSCD_DE_3P5DB};
        4'h3: demph_lut = {`PSCD_SW_09, `PSCD_DE_0DB};
        4'h4: demph_lut = {`PSCD_SW_09, `PSCD_DE_3P5DB};
        4'h5: demph_lut = {`PSCD_SW_09, `PSCD_DE_6DB};
        4'h6: demph_lut = {`PSCD_SW_10, `PSCD_DE_0DB};
        4'h7: demph_lut = {`PSCD_SW_10, `PSCD_DE_3P5DB};
        4'h8: demph_lut = {`PSCD_SW_10, `PSCD_DE_6DB};
        4'h9: demph_lut = {`PSCD_SW_11, `PSCD_DE_0DB};
        4'ha: demph_lut = {`PSCD_SW_11, `PSCD_DE_3P5DB};
        4'hb: demph_lut = {`PSCD_SW_11, `PSCD_DE_6DB};
        4'hc: demph_lut = {`PSCD_SW_12, `PSCD_DE_0DB};
        4'hd: demph_lut = {`PSCD_SW_12, `PSCD_DE_3P5DB};
        4'he: demph_lut = {`PSCD_SW_12, `PSCD_DE_6DB};
        default: demph_lut = {`PSCD_SW_12, `PSCD_DE_9DB};
      endcase
    end
  endfunction

  // Per-side decode, D and S independent
  wire [7:0] d_boost_w = boost_lut({d_eq_hi_w, d_eq_lo_w});
  wire [7:0] s_boost_w = boost_lut({s_eq_hi_w, s_eq_lo_w});
  wire [5:0] d_dem_w = demph_lut({d_de_hi_w, d_de_lo_w});
  wire [5:0] s_dem_w = demph_lut({s_de_hi_w, s_de_lo_w});

  ////////////////////////////////////////////////////////////////////////
  // Per-lane register bank; full 8-bit boost range reachable
  reg [7:0] boost_q [0:LANES-1];
  reg [3:0] swing_q [0:LANES-1];
  reg [1:0] deemph_q [0:LANES-1];
  reg [LANES-1:0] term_q;
  integer i;

  // Bank update: mode low clears, hold pin in slave mode freezes
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (i = 0; i < LANES; i = i + 1)
      begin
        boost_q[i] <= `PSCD_DEF_EQ; // Power-up defaults
        swing_q[i] <= `PSCD_DEF_SW;
        deemph_q[i] <= `PSCD_DEF_DE;
      end
      term_q <= {LANES{`PSCD_DEF_TERM}};
    end
    else if (pin_mode_w)
    begin
      for (i = 0; i < LANES; i = i + 1)
      begin
        boost_q[i] <= `PSCD_DEF_EQ; // Mode pin low resets
        swing_q[i] <= `PSCD_DEF_SW;
        deemph_q[i] <= `PSCD_DEF_DE;
      end
      term_q <= {LANES{`PSCD_DEF_TERM}};
    end
    else if (reg_wr_i && !(hold_w && mode_w == `PSCD_MODE_SLAVE))
    begin
      // Each lane written on its own
      boost_q[reg_lane_i] <= reg_boost_i;
      swing_q[reg_lane_i] <= reg_swing_i;
      deemph_q[reg_lane_i] <= reg_deemph_i;
      term_q[reg_lane_i] <= reg_term_dis_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output select; lanes below half are D side, rest S side
  // Selection follows the decoded mode with no extra event
  integer k;
  reg [8*LANES-1:0] boost_d;
  reg [4*LANES-1:0] swing_d;
  reg [2*LANES-1:0] deemph_d;
  reg [LANES-1:0] term_d;
  always @*
  begin
    for (k = 0; k < LANES; k = k + 1)
    begin
      if (pin_mode_w) // Straps track live levels
      begin
        boost_d[8*k +: 8] = (k < LANES/2) ? d_boost_w : s_boost_w;
        swing_d[4*k +: 4] = (k < LANES/2) ? d_dem_w[5:2] : s_dem_w[5:2];
        deemph_d[2*k +: 2] = (k < LANES/2) ? d_dem_w[1:0] : s_dem_w[1:0];
        term_d[k] = `PSCD_DEF_TERM;
      end
      else
      begin
        boost_d[8*k +: 8] = boost_q[k]; // Registers rule at once
        swing_d[4*k +: 4] = swing_q[k];
        deemph_d[2*k +: 2] = deemph_q[k];
        term_d[k] = term_q[k];
      end
    end
  end

  // Registered outputs; address straps only meaningful in bus modes
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode_o <= `PSCD_MODE_PIN;
      bus_addr_straps_o <= 4'h0;
      ctle_boost_o <= {LANES{`PSCD_DEF_EQ}};
      output_swing_o <= {LANES{`PSCD_DEF_SW}};
      deemph_o <= {LANES{`PSCD_DEF_DE}};
      term_dis_o <= {LANES{`PSCD_DEF_TERM}};
    end
    else
    begin
      mode_o <= mode_w;
      // Hi straps of each group reused as address bits
      bus_addr_straps_o <= pin_mode_w ? 4'h0 :
        {s_de_hi_w[1], d_de_hi_w[1], s_eq_hi_w[1], d_eq_hi_w[1]};
      ctle_boost_o <= boost_d;
      output_swing_o <= swing_d;
      deemph_o <= deemph_d;
      term_dis_o <= term_d;
    end
  end

endmodule // pscd_strap_decoder
